// File: ddr_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; ready and valid come straight from flops.
module ddr_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4,
    parameter int AW    = 2
)(
    input  wire logic         clk,        // System clock
    input  wire logic         sys_rst,    // Synchronous reset
    input  wire logic         in_valid,   // Word offered
    input  wire logic [W-1:0] in_data,    // Word to store
    output logic              in_ready,   // Room for a word
    output logic              out_valid,  // Word available
    output logic      [W-1:0] out_data,   // Oldest word
    input  wire logic         out_ready   // Drain takes the word
);
    logic [W-1:0] mem [DEPTH];            // Storage
    logic [AW-1:0] wp_q;                  // Write pointer
    logic [AW-1:0] rp_q;                  // Read pointer
    logic [AW:0]   cnt_q;                 // Fill level
    logic [AW:0]   cnt_d;                 // Next fill level
    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;
    assign cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data = mem[rp_q];
    // ------------------------------------------------------------
    // Pointers and flags
    // ------------------------------------------------------------
    // Flags registered from the next level so back-pressure is honest
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wp_q      <= '0;
            rp_q      <= '0;
            cnt_q     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wp_q      <= wp_q + AW'(push);
            rp_q      <= rp_q + AW'(pop);
            cnt_q     <= cnt_d;
            in_ready  <= cnt_d != (AW+1)'(DEPTH);
            out_valid <= cnt_d != '0;
        end
    end
    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end
endmodule

// File: ddr_io_datapath.sv
// One strobe group of the external memory I/O datapath.
// Assumes an external delay cell feeds rd_strobe_clk from the strobe pin.
// How it works
// - Group is strobe, mask pin, up to eighteen data
// - Widths 8/9 or 16/18 per group
// - One parity bit per eight data bits
// - Mask pin low writes, high masks byte
// - Every group has its own mask pin
// - Divider makes system clock and write clock
// - Strobe, command, address launched on system clock
// - Write clock leads by ninety degrees, launches data
// - Programmable delay centres read strobe in eye
// - Delayed strobe clocks the read capture registers
// - Strobe may be bidirectional or read-only clock
// - Memory clock at most 167 MHz
module ddr_io_datapath
    import ddr_io_pkg::*;
#(
    parameter int BYTES   = 1,            // 1: x8/x9 group, 2: x16/x18 group
    parameter int PAR_BIT = 8,            // Lane pin that carries parity
    parameter int ADDR_W  = 13            // Address pin width
)(
    input  wire logic                   clk,           // System clock
    input  wire logic                   sys_rst,       // Synchronous reset
    input  wire logic                   rd_strobe_clk, // Delayed read strobe
    input  wire logic                   wr_valid,      // Write word offered
    input  wire logic [2*BYTES*8-1:0]   wr_data,       // {fall beat, rise beat}
    input  wire logic [1:0]             wr_mask,       // {fall, rise} mask
    output logic                        wr_ready,      // Buffer has room
    input  wire logic                   cmd_valid,     // Command waiting
    input  wire logic [CMD_W-1:0]       cmd_code,      // Command code
    input  wire logic [ADDR_W-1:0]      cmd_addr,      // Command address
    output logic                        cmd_ack,       // Command launched
    input  wire logic                   par_en,        // Parity on ninth pins
    input  wire logic                   rd_clk_mode,   // Strobe is read clock
    input  wire logic [TAP_W-1:0]       dly_tap_in,    // Strobe delay setting
    output logic                        rd_valid,      // Read pair pulse
    output logic [2*BYTES*8-1:0]        rd_data,       // {fall beat, rise beat}
    output logic                        rd_par_err,    // Parity mismatch
    output logic                        mem_ck,        // Memory system clock
    output logic                        mem_wr_ck,     // Write clock
    output logic [CMD_W-1:0]            mem_cmd,       // Command pins
    output logic [ADDR_W-1:0]           mem_addr,      // Address pins
    output logic [BYTES*9-1:0]          dq_o,          // Data pin drive
    output logic                        dq_oe,         // Data pin enable
    input  wire logic [BYTES*9-1:0]     dq_i,          // Data pin level
    output logic                        dm_o,          // Mask pin
    output logic                        dqs_o,         // Strobe pin drive
    output logic                        dqs_oe,        // Strobe pin enable
    output logic [TAP_W-1:0]            dqs_dly_tap    // To strobe delay cell
);
    // ------------------------------------------------------------
    // Sizes and lane helpers
    // ------------------------------------------------------------
    localparam int DATA_W = BYTES * BYTE_W;
    localparam int DQ_W   = BYTES * LANE_W;
    localparam int FIFO_W = 2 * (DATA_W + 1);

    // Place data and parity into lanes of nine pins
    function automatic logic [DQ_W-1:0] pack(input logic [DATA_W-1:0] d,
                                             input logic pe);
        logic [DQ_W-1:0] w;
        w = '0;
        for (int b = 0; b < BYTES; b++) begin
            for (int k = 0; k < LANE_W; k++) begin
                if (k == PAR_BIT) begin
                    w[b*LANE_W+k] = pe & (^d[b*BYTE_W +: BYTE_W]);
                end else begin
                    w[b*LANE_W+k] = d[b*BYTE_W + ((k < PAR_BIT) ? k : k-1)];
                end
            end
        end
        return w;
    endfunction

    // Data bits of a lane word
    function automatic logic [DATA_W-1:0] unpack(input logic [DQ_W-1:0] w);
        logic [DATA_W-1:0] d;
        d = '0;
        for (int b = 0; b < BYTES; b++) begin
            for (int k = 0; k < LANE_W; k++) begin
                if (k != PAR_BIT) begin
                    d[b*BYTE_W + ((k < PAR_BIT) ? k : k-1)] = w[b*LANE_W+k];
                end
            end
        end
        return d;
    endfunction

    // Parity pins of a lane word
    function automatic logic [BYTES-1:0] par_pins(input logic [DQ_W-1:0] w);
        logic [BYTES-1:0] p;
        p = '0;
        for (int b = 0; b < BYTES; b++) begin
            p[b] = w[b*LANE_W+PAR_BIT];
        end
        return p;
    endfunction

    // Expected parity of each byte
    function automatic logic [BYTES-1:0] calc_par(input logic [DATA_W-1:0] d);
        logic [BYTES-1:0] p;
        p = '0;
        for (int b = 0; b < BYTES; b++) begin
            p[b] = ^d[b*BYTE_W +: BYTE_W];
        end
        return p;
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0]          phase_q;            // Position in memory clock period
    wr_state_type        state_q, state_d;   // Write sequencer
    logic [DQ_W-1:0]     fall_dq_q;          // Fall beat waiting for launch
    logic                fall_dm_q;          // Fall mask waiting for launch
    logic                fifo_valid;         // Buffered word present
    logic [FIFO_W-1:0]   fifo_data;          // Buffered word
    logic                pair_valid;         // Read pair arrived
    logic [2*DQ_W-1:0]   pair_data;          // Read pair pins

    wire ld_rise    = phase_q == PH_WR_RISE;
    wire ld_fall    = phase_q == PH_WR_FALL;
    wire ck_next    = (phase_q == PH_SYS_RISE) | (phase_q == PH_WR_FALL);
    wire wr_ck_next = (phase_q == PH_WR_RISE) | (phase_q == PH_SYS_RISE);
    wire in_burst   = (state_q == WS_PRE) | (state_q == WS_BURST);
    wire pop        = ld_rise & fifo_valid & in_burst;
    wire [DATA_W-1:0] beat_r = fifo_data[DATA_W-1:0];
    wire              mask_r = fifo_data[DATA_W];
    wire [DATA_W-1:0] beat_f = fifo_data[2*DATA_W:DATA_W+1];
    wire              mask_f = fifo_data[FIFO_W-1];
    wire [DQ_W-1:0]   pr_r   = pair_data[DQ_W-1:0];
    wire [DQ_W-1:0]   pr_f   = pair_data[2*DQ_W-1:DQ_W];
    wire par_bad = (calc_par(unpack(pr_r)) != par_pins(pr_r))
                 | (calc_par(unpack(pr_f)) != par_pins(pr_f));

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    ddr_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH),
        .AW    ($clog2(FIFO_DEPTH))
    ) u_wr_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (wr_valid),
        .in_data   ({wr_mask[1], wr_data[2*DATA_W-1:DATA_W],
                     wr_mask[0], wr_data[DATA_W-1:0]}),
        .in_ready  (wr_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (pop)
    );

    // Capture flops run on the delayed strobe
    ddr_rd_capture #(
        .W (DQ_W)
    ) u_rd_capture (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .strobe_clk (rd_strobe_clk),
        .dq_i       (dq_i),
        .pair_valid (pair_valid),
        .pair_data  (pair_data)
    );

    // ------------------------------------------------------------
    // Clock generation
    // ------------------------------------------------------------
    // Divide by four; memory clock is 5 MHz, far under 167 MHz
    // Leaving reset at the write rise keeps the write clock a quarter ahead
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_q   <= PH_WR_RISE;
            mem_ck    <= 1'b0;
            mem_wr_ck <= 1'b0;
        end else begin
            phase_q   <= phase_q + 2'h1;
            mem_ck    <= ck_next;
            mem_wr_ck <= wr_ck_next;      // Leads mem_ck by a quarter
        end
    end

    // ------------------------------------------------------------
    // Write sequencer
    // ------------------------------------------------------------
    // Preamble period, data periods while words remain, postamble
    always_comb begin
        state_d = state_q;
        case (state_q)
            WS_IDLE: begin
                if (ld_rise & fifo_valid) begin
                    state_d = WS_PRE;
                end
            end
            WS_PRE: begin
                if (ld_rise) begin
                    state_d = fifo_valid ? WS_BURST : WS_POST;
                end
            end
            WS_BURST: begin
                if (ld_rise & !fifo_valid) begin
                    state_d = WS_POST;
                end
            end
            default: begin
                if (ld_rise) begin
                    state_d = WS_IDLE;
                end
            end
        endcase
    end

    // State and strobe pin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= WS_IDLE;
            dqs_o   <= 1'b0;
            dqs_oe  <= 1'b0;
        end else begin
            state_q <= state_d;
            dqs_o   <= (state_q == WS_BURST) & ck_next;
            dqs_oe  <= (state_q != WS_IDLE) & !rd_clk_mode;
        end
    end

    // Data and mask launched on write clock edges
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dq_o      <= '0;
            dq_oe     <= 1'b0;
            dm_o      <= 1'b0;
            fall_dq_q <= '0;
            fall_dm_q <= 1'b0;
        end else if (ld_rise) begin
            dq_oe     <= pop;
            dq_o      <= pop ? pack(beat_r, par_en) : '0;
            dm_o      <= pop & mask_r;
            fall_dq_q <= pack(beat_f, par_en);
            fall_dm_q <= pop & mask_f;
        end else if (ld_fall & dq_oe) begin
            dq_o      <= fall_dq_q;
            dm_o      <= fall_dm_q;
        end
    end

    // ------------------------------------------------------------
    // Commands and strobe delay
    // ------------------------------------------------------------
    // Command and address change with the system clock rise
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_cmd     <= CMD_NOP;
            mem_addr    <= '0;
            cmd_ack     <= 1'b0;
            dqs_dly_tap <= DLY_TAP_RST;
        end else begin
            cmd_ack     <= cmd_valid & (phase_q == PH_SYS_RISE);
            if (phase_q == PH_SYS_RISE) begin
                mem_cmd  <= cmd_valid ? cmd_code : CMD_NOP;
                mem_addr <= cmd_valid ? cmd_addr : mem_addr;
            end
            dqs_dly_tap <= dly_tap_in;
        end
    end

    // ------------------------------------------------------------
    // Read output
    // ------------------------------------------------------------
    // Strip parity pins and flag mismatches
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_valid   <= 1'b0;
            rd_data    <= '0;
            rd_par_err <= 1'b0;
        end else begin
            rd_valid   <= pair_valid;
            rd_par_err <= pair_valid & par_en & par_bad;
            if (pair_valid) begin
                rd_data <= {unpack(pr_f), unpack(pr_r)};
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_rise_beat;
        dm_o == $past(mask_r) && dq_o == $past(pack(beat_r, par_en));
    endsequence
    sequence s_fall_beat;
        dm_o == $past(mask_f, 3) && dq_o == $past(pack(beat_f, par_en), 3);
    endsequence

    a_mask_beats: assert property (pop |=> s_rise_beat ##1 1'b1 ##1 s_fall_beat)
        else $error("mask or data beat wrong after pop");
    a_ck_period: assert property ($rose(mem_ck) |=> !$rose(mem_ck) [*3] ##1 $rose(mem_ck))
        else $error("memory clock period not four cycles");
    a_wr_ck_lead: assert property ($rose(mem_wr_ck) |=> $rose(mem_ck))
        else $error("write clock not a quarter ahead");
    a_dq_on_wr_ck: assert property ($changed(dq_o) |-> $changed(mem_wr_ck))
        else $error("data changed off a write clock edge");
    a_cmd_on_ck: assert property ($changed(mem_cmd) |-> $rose(mem_ck))
        else $error("command changed off system clock rise");
    a_dqs_on_ck: assert property ($changed(dqs_o) |-> $changed(mem_ck))
        else $error("strobe changed off system clock edge");
    a_par_out: assert property (dq_oe && par_en |-> calc_par(unpack(dq_o)) == par_pins(dq_o))
        else $error("driven parity pin wrong");
    a_rd_pair: assert property (pair_valid |=> rd_valid && rd_data == $past({unpack(pr_f), unpack(pr_r)}))
        else $error("read pair not delivered");
    a_rdclk_mode: assert property (rd_clk_mode |=> !dqs_oe)
        else $error("strobe driven in read clock mode");
    a_dly_follow: assert property (##1 dqs_dly_tap == $past(dly_tap_in))
        else $error("delay setting not applied");
endmodule

// File: ddr_io_pkg.sv
// Shared constants and types for the memory I/O datapath.
// Assumes a 20 MHz system clock feeding every clk port.
package ddr_io_pkg;
    // ------------------------------------------------------------
    // Clock plan
    // ------------------------------------------------------------
    localparam int CLK_HZ       = 20_000_000;   // System clock rate
    localparam int CLK_DIV      = 4;            // clk cycles per memory clock
    localparam int MEM_HZ       = CLK_HZ / CLK_DIV;
    localparam int MEM_MAX_HZ   = 167_000_000;  // Top memory clock rate
    localparam int MEM_MAX_MBPS = 333;          // Top rate per data pin
    // Phase counter codes; each names the edge launched next
    localparam logic [1:0] PH_SYS_RISE = 2'h0;
    localparam logic [1:0] PH_WR_FALL  = 2'h1;
    localparam logic [1:0] PH_SYS_FALL = 2'h2;
    localparam logic [1:0] PH_WR_RISE  = 2'h3;
    // ------------------------------------------------------------
    // Group layout
    // ------------------------------------------------------------
    localparam int LANE_W     = 9;              // Pins per byte lane
    localparam int BYTE_W     = 8;              // Data bits per lane
    localparam int TAP_W      = 4;              // Strobe delay setting width
    localparam logic [3:0] DLY_TAP_RST = 4'h0;  // Delay setting after reset
    localparam int FIFO_DEPTH = 4;              // Write buffer words
    localparam int CMD_W      = 3;              // Command pin width
    localparam logic [2:0] CMD_NOP = 3'h7;      // Idle command code
    typedef enum logic [1:0] {
        WS_IDLE  = 2'b00,
        WS_PRE   = 2'b01,
        WS_BURST = 2'b10,
        WS_POST  = 2'b11
    } wr_state_type;
endpackage

// File: ddr_rd_capture.sv
// Read capture on the delayed strobe plus the crossing to clk.
// Assumes the strobe toggles at least three times during sys_rst.
// Assumes one spare strobe cycle ahead of each pair, as reset and ack
// only move on strobe rises and the strobe stops between frames.
module ddr_rd_capture #(
    parameter int W = 9
)(
    input  wire logic           clk,         // System clock
    input  wire logic           sys_rst,     // Synchronous reset, clk domain
    input  wire logic           strobe_clk,  // Delayed read strobe
    input  wire logic [W-1:0]   dq_i,        // Data pins
    output logic                pair_valid,  // One-cycle pulse, clk domain
    output logic [2*W-1:0]      pair_data    // {fall beat, rise beat}
);
    logic rst_s1, rst_s2;                    // Reset into strobe domain
    logic ack_s1, ack_s2;                    // Ack into strobe domain
    logic req_q;                             // Toggle per published pair
    logic [W-1:0]   rise_q;                  // Beat caught on rising edge
    logic [2*W-1:0] hold_q;                  // Stable pair for crossing
    logic req_s1, req_s2, req_s3;            // Request into clk domain
    wire busy = req_q ^ ack_s2;
    // ------------------------------------------------------------
    // Strobe domain
    // ------------------------------------------------------------
    // Synchronisers for reset and acknowledge
    always_ff @(posedge strobe_clk) begin
        rst_s1 <= sys_rst;
        rst_s2 <= rst_s1;
        ack_s1 <= req_s2;
        ack_s2 <= ack_s1;
    end
    // Rising beat
    always_ff @(posedge strobe_clk) begin
        rise_q <= dq_i;
    end
    // Falling beat completes the pair; dropped while a pair is in flight
    always_ff @(negedge strobe_clk) begin
        if (rst_s2) begin
            req_q <= 1'b0;
        end else if (!busy) begin
            hold_q <= {dq_i, rise_q};
            req_q  <= ~req_q;
        end
    end
    // ------------------------------------------------------------
    // System clock domain
    // ------------------------------------------------------------
    // Toggle synchroniser and edge detect; hold_q is stable here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_s1     <= 1'b0;
            req_s2     <= 1'b0;
            req_s3     <= 1'b0;
            pair_valid <= 1'b0;
            pair_data  <= '0;
        end else begin
            req_s1     <= req_q;
            req_s2     <= req_s1;
            req_s3     <= req_s2;
            pair_valid <= req_s2 ^ req_s3;
            if (req_s2 ^ req_s3) begin
                pair_data <= hold_q;
            end
        end
    end
endmodule

// File: mem_model.sv
// External memory stand-in for one x8/x9 strobe group.
// Assumes clk is the 50 ns system clock of the datapath.
module mem_model (
    input  wire logic       clk,     // System clock
    input  wire logic       dq_oe,   // Device drives data
    input  wire logic [8:0] dq_o,    // Data pins from device
    input  wire logic       dm_o,    // Mask pin
    input  wire logic       wr_ck,   // Write clock
    output logic            strobe,  // Read strobe
    output logic      [8:0] dq       // Read data pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] got[$];  // Unmasked beats stored
    logic       ck_q;    // Last write clock level
    initial begin
        strobe = 1'b0;
        dq     = 9'h0;
        ck_q   = 1'b0;
    end
    // A beat lands on each write clock edge; masked beats are ignored
    always @(negedge clk) begin
        if (dq_oe === 1'b1 && wr_ck !== ck_q && dm_o === 1'b0) begin
            got.push_back(dq_o);
        end
        ck_q = wr_ck;
    end
    // Read-only strobe, 12 ns period, low between frames; data inverted after
    // A spare lead cycle carries the capture side's reset release and ack
    task automatic pulse(input logic [8:0] a, input logic [8:0] b);
        #($urandom_range(0, 11));
        dq = ~a;
        #3 strobe = 1'b1;
        #6 strobe = 1'b0;
        #3 dq = a;
        #3 strobe = 1'b1;
        #3 dq = b;
        #3 strobe = 1'b0;
        #3 dq = ~b;
    endtask
endmodule

// File: test_ddr_memory_io_datapath.sv
// Self-checking bench for one x8/x9 strobe group of the memory datapath.
// Assumes mem_model drives the read strobe and the data pins.
module test_ddr_memory_io_datapath import ddr_io_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, sys_rst = 1'b1, strobe, wr_valid, wr_ready, cmd_valid, cmd_ack;
    logic par_en, rd_clk_mode, rd_valid, rd_par_err, mem_ck, mem_wr_ck, dq_oe, dm_o, dqs_oe;
    logic [15:0] wr_data, rd_data, d;
    logic [1:0]  wr_mask, m;
    logic [2:0]  cmd_code, mem_cmd, code;
    logic [12:0] cmd_addr, mem_addr, addr;
    logic [3:0]  dly_tap_in, dqs_dly_tap, tap;
    logic [8:0]  dq_o, dq_i;
    logic [7:0]  a, b;
    logic [8:0]  exp_q[$];
    logic        full_seen, ck_d, pe, bad;
    int          err_count = 0;
    int          num_checks = 0;
    int          n;
    always #25 clk = ~clk;
    ddr_io_datapath DUT (.clk(clk), .sys_rst(sys_rst), .rd_strobe_clk(strobe),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_mask(wr_mask), .wr_ready(wr_ready),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_ack(cmd_ack),
        .par_en(par_en), .rd_clk_mode(rd_clk_mode), .dly_tap_in(dly_tap_in),
        .rd_valid(rd_valid), .rd_data(rd_data), .rd_par_err(rd_par_err), .mem_ck(mem_ck),
        .mem_wr_ck(mem_wr_ck), .mem_cmd(mem_cmd), .mem_addr(mem_addr), .dq_o(dq_o),
        .dq_oe(dq_oe), .dq_i(dq_i), .dm_o(dm_o), .dqs_o(), .dqs_oe(dqs_oe),
        .dqs_dly_tap(dqs_dly_tap));
    mem_model mem (.clk(clk), .dq_oe(dq_oe), .dq_o(dq_o), .dm_o(dm_o), .wr_ck(mem_wr_ck),
        .strobe(strobe), .dq(dq_i));
    // Compare and count
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (err_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Lane pins: parity on the ninth pin
    function automatic logic [8:0] pin(input logic [7:0] v);
        return {^v, v};
    endfunction
    // Offer one word, hold until taken
    task automatic put(input logic [15:0] v, input logic [1:0] k);
        wr_valid <= 1'b1;
        wr_data  <= v;
        wr_mask  <= k;
        do begin
            @(posedge clk);
            if (wr_ready !== 1'b1) full_seen = 1'b1;
        end while (wr_ready !== 1'b1);
    endtask
    // Memory clock trails the write clock by one clk cycle
    always @(negedge clk) begin
        if (!sys_rst) check("wr_ck_lead", 32'(mem_ck), 32'(ck_d));
        ck_d = mem_wr_ck;
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        end_of_test();
    end
    initial begin
        {wr_valid, cmd_valid, par_en, rd_clk_mode, full_seen, ck_d} = 6'h0;
        {wr_data, wr_mask, cmd_code, cmd_addr, dly_tap_in} = 38'h0;
        void'($urandom(32'h390acb60));
        repeat (4) mem.pulse(9'($urandom), 9'($urandom));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        check("wr_ready", 32'(wr_ready), 32'h1);
        check("mem_cmd_idle", 32'(mem_cmd), 32'(CMD_NOP));
        // Commands launch with the system clock rise
        repeat (4) begin
            code = 3'($urandom_range(0, 6));
            addr = 13'($urandom);
            cmd_valid <= 1'b1;
            cmd_code  <= code;
            cmd_addr  <= addr;
            n = 0;
            do begin @(posedge clk); n++; end while (cmd_ack !== 1'b1 && n < 8);
            cmd_valid <= 1'b0;
            check("mem_cmd", 32'(mem_cmd), 32'(code));
            check("mem_addr", 32'(mem_addr), 32'(addr));
            check("mem_ck", 32'(mem_ck), 32'h1);
            @(posedge clk);
        end
        // Delay setting, both end values first
        for (int i = 0; i < 4; i++) begin
            tap = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
            dly_tap_in <= tap;
            repeat (2) @(posedge clk);
            check("dqs_dly_tap", 32'(dqs_dly_tap), 32'(tap));
        end
        // Read pairs, parity on and off, some corrupted
        for (int i = 0; i < 6; i++) begin
            a = 8'($urandom);
            b = 8'($urandom);
            bad = (i == 0) | 1'($urandom);
            pe = (i < 2) | 1'($urandom);
            par_en <= pe;
            rd_clk_mode <= 1'($urandom);
            @(posedge clk);
            mem.pulse(pin(a), pin(b) ^ {bad, 8'h0});
            n = 0;
            do begin @(posedge clk); n++; end while (rd_valid !== 1'b1 && n < 20);
            check("rd_data", 32'(rd_data), 32'({b, a}));
            check("rd_par_err", 32'(rd_par_err), 32'(pe & bad));
            check("dqs_oe", 32'(dqs_oe), 32'h0);
            repeat (10) @(posedge clk);
        end
        // Back-to-back writes fill the buffer; masked beats must not land
        par_en <= 1'b1;
        rd_clk_mode <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            d = 16'($urandom);
            m = (i < 2) ? 2'b00 : (i == 2) ? 2'b11 : 2'($urandom);
            put(d, m);
            if (!m[0]) exp_q.push_back(pin(d[7:0]));
            if (!m[1]) exp_q.push_back(pin(d[15:8]));
        end
        wr_valid <= 1'b0;
        check("dqs_oe_write", 32'(dqs_oe), 32'h1);
        repeat (60) @(posedge clk);
        check("buffer_full", 32'(full_seen), 32'h1);
        check("beat_count", 32'(mem.got.size()), 32'(exp_q.size()));
        while (exp_q.size() > 0 && mem.got.size() > 0)
            check("write_beat", 32'(mem.got.pop_front()), 32'(exp_q.pop_front()));
        end_of_test();
    end
endmodule
